// ==== include/mrcoc_params.svh ====
`ifndef MRCOC_PARAMS_SVH
`define MRCOC_PARAMS_SVH
// register byte offsets
`define MRCOC_OFS_CTRL      8'h00
`define MRCOC_OFS_BANK0     8'h04
`define MRCOC_OFS_STATUS    8'h14
// control register fields
`define MRCOC_CTRL_BYPASS   0
`define MRCOC_CTRL_PWRDN    1
`define MRCOC_CTRL_MMC_LSB  4
`define MRCOC_CTRL_RST      8'h00
// bank config fields
`define MRCOC_CFG_DIFF      4
`define MRCOC_CFG_EN        5
`define MRCOC_CFG_FRAC      6
`define MRCOC_CFG_RST       7'h20
// strap tables: level per select code, bank four by index
`define MRCOC_B3_DIFF_MASK  3'h5
`define MRCOC_B2_DIFF_MASK  3'h7
`define MRCOC_B1_DIFF_MASK  3'h0
`define MRCOC_B4_DIFF_MASK  9'h178
`define MRCOC_B4_FRAC_MASK  9'h14E
// timing
`define MRCOC_CLK_PERIOD_NS 10
`define MRCOC_RETUNE_NS     1000
`define MRCOC_RETUNE_CYC \
  ((`MRCOC_RETUNE_NS + `MRCOC_CLK_PERIOD_NS - 1) / `MRCOC_CLK_PERIOD_NS)
`endif

// ==== include/mrcoc_pkg.sv ====
`default_nettype none
package mrcoc_pkg;
  typedef enum logic [2:0] {
    MRCOC_OFF  = 3'h1,
    MRCOC_WAIT = 3'h2,
    MRCOC_RUN  = 3'h4
  } mrcoc_pwr_t;
  typedef enum logic [1:0] {
    MRCOC_LVL_LOW  = 2'h0,
    MRCOC_LVL_MID  = 2'h1,
    MRCOC_LVL_HIGH = 2'h2
  } mrcoc_lvl_t;
  typedef logic [6:0] mrcoc_cfg_t;
endpackage : mrcoc_pkg
`default_nettype wire

// ==== core/mrcoc_ctrl.sv ====
`include "mrcoc_params.svh"
`default_nettype none
module mrcoc_ctrl
  import mrcoc_pkg::*;
#(
  parameter int RETUNE_CYC = `MRCOC_RETUNE_CYC
) (
  // clock and reset
  input  wire  logic        aclk,
  input  wire  logic        aresetn,
  // axi4-lite write
  input  wire  logic [7:0]  awaddr,
  input  wire  logic        awvalid,
  output logic              awready,
  input  wire  logic [31:0] wdata,
  input  wire  logic [3:0]  wstrb,
  input  wire  logic        wvalid,
  output logic              wready,
  output logic [1:0]        bresp,
  output logic              bvalid,
  input  wire  logic        bready,
  // axi4-lite read
  input  wire  logic [7:0]  araddr,
  input  wire  logic        arvalid,
  output logic              arready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  output logic              rvalid,
  input  wire  logic        rready,
  // pins, three-level selects as {above_mid, above_low}
  input  wire  logic [1:0]  freq_select_bank_one,
  input  wire  logic [1:0]  freq_select_bank_two,
  input  wire  logic [1:0]  freq_select_bank_three,
  input  wire  logic [1:0]  freq_select_bank_four_first,
  input  wire  logic [1:0]  freq_select_bank_four_second,
  input  wire  logic        serial_data,
  input  wire  logic        serial_clock_or_powerdown,
  input  wire  logic        mixed_mode_ctrl,
  input  wire  logic        pll_locked,
  // bank and pll control
  output logic [3:0]        bank_run_q,
  output logic [3:0]        bank_true_output_q,
  output logic [3:0]        bank_complement_output_q,
  output logic [15:0]       bank_freq_q,
  output logic [3:0]        bank_diff_q,
  output logic              bank4_frac_q,
  output logic              pll_bypass_q,
  output logic              pll_powerdown_q
);

  localparam int NS = 14;

  function automatic logic [1:0] lvl_dec(input logic [1:0] p);
    lvl_dec = (p == 2'h3) ? MRCOC_LVL_HIGH :
              (p == 2'h0) ? MRCOC_LVL_LOW : MRCOC_LVL_MID;
  endfunction : lvl_dec

  function automatic logic [31:0] wmerge(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      o[i*8 +: 8] = s[i] ? d[i*8 +: 8] : o[i*8 +: 8];
    end
    wmerge = o;
  endfunction : wmerge

  // three-stage pin synchronisers, value moves when stages 2 and 3 agree
  logic [NS-1:0] s1_q, s2_q, s3_q, pin_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      pin_q <= '0;
    end else begin
      s1_q  <= {pll_locked, mixed_mode_ctrl, serial_clock_or_powerdown,
                serial_data, freq_select_bank_four_second,
                freq_select_bank_four_first, freq_select_bank_three,
                freq_select_bank_two, freq_select_bank_one};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pin_q <= (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));
    end
  end

  logic pll_ok, mmc_f, pd_f, sda_f;
  assign pll_ok = pin_q[13];
  assign mmc_f  = pin_q[12];
  assign pd_f   = pin_q[11];
  assign sda_f  = pin_q[10];

  // serial mode latch, cleared only by power-up reset
  logic serial_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_q <= 1'b0;
    end else if (sda_f) begin
      serial_q <= 1'b1;
    end
  end

  // register file
  logic [7:0]  ctrl_q;
  mrcoc_cfg_t  cfg_q [4];
  mrcoc_pwr_t  pst_q;
  logic        awgot_q, wgot_q;
  logic [7:0]  awa_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;
  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awgot_q   <= 1'b0;
      wgot_q    <= 1'b0;
      awa_q     <= 8'h00;
      wd_q      <= 32'h0000_0000;
      ws_q      <= 4'h0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      ctrl_q    <= `MRCOC_CTRL_RST;
      for (int b = 0; b < 4; b++) begin
        cfg_q[b] <= `MRCOC_CFG_RST;
      end
    end else begin
      if (awvalid && awready_q) begin
        awgot_q   <= 1'b1;
        awa_q     <= awaddr;
        awready_q <= 1'b0;
      end
      if (wvalid && wready_q) begin
        wgot_q   <= 1'b1;
        wd_q     <= wdata;
        ws_q     <= wstrb;
        wready_q <= 1'b0;
      end
      if (awgot_q && wgot_q && !bvalid_q) begin
        awgot_q  <= 1'b0;
        wgot_q   <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= 2'h0;
        if (awa_q == `MRCOC_OFS_CTRL) begin
          ctrl_q <= 8'(wmerge({24'h0, ctrl_q}, wd_q, ws_q));
        end else if (awa_q >= `MRCOC_OFS_BANK0 &&
                     awa_q < `MRCOC_OFS_STATUS && awa_q[1:0] == 2'h0) begin
          cfg_q[awa_q[3:2] - 2'h1] <= 7'(
            wmerge({25'h0, cfg_q[awa_q[3:2] - 2'h1]}, wd_q, ws_q));
        end else if (awa_q != `MRCOC_OFS_STATUS) begin
          bresp_q <= 2'h2;
        end
      end
      if (bvalid_q && bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= 2'h0;
      rdata_q   <= 32'h0000_0000;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= 2'h0;
      rdata_q   <= 32'h0000_0000;
      if (araddr == `MRCOC_OFS_CTRL) begin
        rdata_q <= {24'h0, ctrl_q};
      end else if (araddr == `MRCOC_OFS_STATUS) begin
        rdata_q <= {23'h0, bank_run_q, pst_q, pll_ok, serial_q};
      end else if (araddr >= `MRCOC_OFS_BANK0 &&
                   araddr < `MRCOC_OFS_STATUS && araddr[1:0] == 2'h0) begin
        rdata_q <= {25'h0, cfg_q[araddr[3:2] - 2'h1]};
      end else begin
        rresp_q <= 2'h2;
      end
    end else if (rvalid_q && rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // power sequencing
  logic pd_req;
  // both lines rising together is a mode exit, not a power-down
  assign pd_req = serial_q ? ctrl_q[`MRCOC_CTRL_PWRDN] :
                  (pd_f && !sda_f);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pst_q <= MRCOC_WAIT;
    end else begin
      case (pst_q)
        MRCOC_WAIT: begin
          if (pd_req) pst_q <= MRCOC_OFF;
          else if (pll_ok) pst_q <= MRCOC_RUN;
        end
        MRCOC_RUN: begin
          if (pd_req) pst_q <= MRCOC_OFF;
          else if (!pll_ok) pst_q <= MRCOC_WAIT;
        end
        MRCOC_OFF: begin
          if (!pd_req) pst_q <= MRCOC_WAIT;
        end
        default: pst_q <= MRCOC_WAIT;
      endcase
    end
  end

  // effective per-bank selection
  logic [1:0] lv [5];
  logic [3:0] sfreq [4];
  logic [3:0] sdiff, sfrac, en_d, diff_d, frac_d, use_strap;
  logic [3:0] freq_d [4];
  logic [5:0] key_d [4];
  logic [3:0] b4i;
  always_comb begin
    for (int p = 0; p < 5; p++) begin
      lv[p] = lvl_dec(pin_q[p*2 +: 2]);
    end
    b4i = 4'(lv[3] * 3 + lv[4]);
    for (int b = 0; b < 3; b++) begin
      sfreq[b] = {2'h0, lv[b]};
      sfrac[b] = 1'b0;
    end
    sdiff[0] = 1'(`MRCOC_B1_DIFF_MASK >> lv[0]);
    sdiff[1] = 1'(`MRCOC_B2_DIFF_MASK >> lv[1]);
    sdiff[2] = 1'(`MRCOC_B3_DIFF_MASK >> lv[2]);
    sfreq[3] = b4i;
    sdiff[3] = 1'(`MRCOC_B4_DIFF_MASK >> b4i);
    sfrac[3] = 1'(`MRCOC_B4_FRAC_MASK >> b4i);
    for (int b = 0; b < 4; b++) begin
      use_strap[b] = !serial_q ||
        (mmc_f && ctrl_q[`MRCOC_CTRL_MMC_LSB + b]);
      freq_d[b] = use_strap[b] ? sfreq[b] : cfg_q[b][3:0];
      diff_d[b] = use_strap[b] ? sdiff[b] : cfg_q[b][`MRCOC_CFG_DIFF];
      frac_d[b] = use_strap[b] ? sfrac[b] :
                  (b == 3) && cfg_q[b][`MRCOC_CFG_FRAC];
      en_d[b]   = !serial_q || cfg_q[b][`MRCOC_CFG_EN];
      key_d[b]  = {frac_d[b], diff_d[b], freq_d[b]};
    end
  end

  // retune hold and bank outputs; banks run unaligned
  logic [5:0]  key_q [4];
  logic [11:0] hold_q [4];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank_run_q               <= 4'h0;
      bank_true_output_q       <= 4'h0;
      bank_complement_output_q <= 4'hF;
      bank_freq_q              <= 16'h0000;
      bank_diff_q              <= 4'h0;
      bank4_frac_q             <= 1'b0;
      pll_bypass_q             <= 1'b0;
      pll_powerdown_q          <= 1'b0;
      for (int b = 0; b < 4; b++) begin
        key_q[b]  <= 6'h00;
        hold_q[b] <= 12'h000;
      end
    end else begin
      pll_powerdown_q <= (pst_q == MRCOC_OFF);
      pll_bypass_q    <= serial_q && ctrl_q[`MRCOC_CTRL_BYPASS];
      bank4_frac_q    <= frac_d[3];
      for (int b = 0; b < 4; b++) begin
        key_q[b] <= key_d[b];
        if (pst_q != MRCOC_RUN) begin
          key_q[b] <= key_d[b];
        end
        if (key_d[b] != key_q[b] && pst_q == MRCOC_RUN) begin
          hold_q[b] <= 12'(RETUNE_CYC);
        end else if (hold_q[b] != 12'h000) begin
          hold_q[b] <= hold_q[b] - 12'h001;
        end
        bank_run_q[b] <= (pst_q == MRCOC_RUN) && en_d[b] &&
                         key_d[b] == key_q[b] && hold_q[b] == 12'h000;
        bank_freq_q[b*4 +: 4]  <= freq_d[b];
        bank_diff_q[b]         <= diff_d[b];
        bank_true_output_q[b]  <= 1'b0;
        bank_complement_output_q[b] <= (pst_q == MRCOC_WAIT) ||
          ((pst_q == MRCOC_RUN) && diff_d[b]);
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_strap_exit_sticky: assert property (serial_q |=> serial_q)
    else $error("serial mode dropped");
  a_hold_until_lock: assert property (
    pst_q != MRCOC_RUN |=> bank_run_q == 4'h0)
    else $error("bank ran before pll stable");
  a_powerup_levels: assert property (pst_q == MRCOC_WAIT |=>
    bank_true_output_q == 4'h0 && bank_complement_output_q == 4'hF)
    else $error("wrong power-up static levels");
  a_disabled_single: assert property (pst_q == MRCOC_RUN && !en_d[1] &&
    !diff_d[1] |=> !bank_run_q[1] && !bank_true_output_q[1] &&
    !bank_complement_output_q[1])
    else $error("single-ended disable level wrong");
  a_disabled_diff: assert property (pst_q == MRCOC_RUN && !en_d[0] &&
    diff_d[0] |=> !bank_run_q[0] && !bank_true_output_q[0] &&
    bank_complement_output_q[0])
    else $error("differential disable level wrong");
  a_strap_no_disable: assert property (!serial_q |-> en_d == 4'hF)
    else $error("strap mode disabled a bank");
  a_strap_pd_enter: assert property (!serial_q && pd_f && !sda_f &&
    pst_q == MRCOC_RUN |=> pst_q == MRCOC_OFF)
    else $error("power-down not entered");
  a_retune_static: assert property (pst_q == MRCOC_RUN &&
    key_d[1] != key_q[1] |=> !bank_run_q[1] ##1 !bank_run_q[1])
    else $error("bank ran through retune");
  a_mmc_ignored: assert property (!serial_q |->
    freq_d[1] == sfreq[1] && diff_d[2] == sdiff[2])
    else $error("strap mode used serial settings");
  a_bank_integer: assert property (frac_d[2:0] == 3'h0)
    else $error("fractional divider on integer bank");
  a_bresp_hold: assert property (bvalid_q && !bready |=>
    bvalid_q && $stable(bresp_q))
    else $error("write response dropped");

  c_serial_entry: cover property (!serial_q ##1 serial_q);
  c_powerdown: cover property (pst_q == MRCOC_RUN ##1 pst_q == MRCOC_OFF);
  c_retune: cover property (hold_q[0] == 12'h001);
  c_write_done: cover property (bvalid_q && bready);

endmodule : mrcoc_ctrl
`default_nettype wire

// ==== testbench/mrcoc_board.sv ====
`default_nettype none
module mrcoc_board (
  // pll side
  input  wire logic pll_powerdown_q,
  input  wire logic lock_allow,
  output logic      pll_locked,
  // serial and strap side
  input  wire logic host_active,
  input  wire logic pd_pin,
  output logic      serial_data,
  output logic      serial_clock_or_powerdown
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lock_q = 1'b0;
  logic seen_q = 1'b0;
  logic scl_q  = 1'b1;
  logic sda_q  = 1'b1;
  // pll drops at once when powered down and settles 200 ns after release
  always @(lock_allow or pll_powerdown_q) begin
    lock_q = 1'b0;
    if (lock_allow && !pll_powerdown_q) begin
      #200;
      lock_q = lock_allow & ~pll_powerdown_q;
    end
  end
  assign pll_locked = lock_q;
  // 125 ns link clock runs only within a host frame
  always #62.5 begin
    if (host_active) begin
      seen_q = 1'b1;
      scl_q = ~scl_q;
      if (!scl_q) sda_q = ~sda_q;
    end else begin
      scl_q = 1'b1;
    end
  end
  // strap board holds the data line low and passes pd_pin on the clock line; a released bus floats high
  assign serial_data = host_active ? sda_q : seen_q;
  assign serial_clock_or_powerdown =
    (host_active | seen_q) ? scl_q : pd_pin;
endmodule : mrcoc_board
`default_nettype wire

// ==== testbench/test_multirate_clock_output_control.sv ====
`include "mrcoc_params.svh"
`default_nettype none
module test_multirate_clock_output_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0]  wstrb = 4'h0, bank_run_q, bank_true_output_q, dx;
  logic [3:0]  bank_complement_output_q, bank_diff_q;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic [1:0]  freq_select_bank_one = 2'h0, freq_select_bank_two = 2'h0;
  logic [1:0]  freq_select_bank_three = 2'h0;
  logic [1:0]  freq_select_bank_four_first = 2'h0;
  logic [1:0]  freq_select_bank_four_second = 2'h0;
  logic        mixed_mode_ctrl = 1'b0, lock_allow = 1'b0;
  logic        host_active = 1'b0, pd_pin = 1'b0;
  logic        watch3 = 1'b0, drop3 = 1'b0;
  logic        pll_locked, serial_data, serial_clock_or_powerdown;
  logic [15:0] bank_freq_q;
  logic        bank4_frac_q, pll_bypass_q, pll_powerdown_q;
  logic [2:0]  d1 = `MRCOC_B1_DIFF_MASK, d2 = `MRCOC_B2_DIFF_MASK;
  logic [2:0]  d3 = `MRCOC_B3_DIFF_MASK;
  logic [8:0]  d4 = `MRCOC_B4_DIFF_MASK, f4 = `MRCOC_B4_FRAC_MASK;
  logic [1:0]  pin_lvl [3] = '{2'h0, 2'h1, 2'h3};
  logic [31:0] rst_exp [6] = '{32'h0, 32'h20, 32'h20, 32'h20, 32'h20, 32'h8};
  int          miscompares = 0, total_checks = 0;

  mrcoc_ctrl #(.RETUNE_CYC(4)) dut_u (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .freq_select_bank_one, .freq_select_bank_two,
    .freq_select_bank_three, .freq_select_bank_four_first,
    .freq_select_bank_four_second, .serial_data, .serial_clock_or_powerdown,
    .mixed_mode_ctrl, .pll_locked, .bank_run_q, .bank_true_output_q,
    .bank_complement_output_q, .bank_freq_q, .bank_diff_q, .bank4_frac_q,
    .pll_bypass_q, .pll_powerdown_q
  );
  mrcoc_board board_u (
    .pll_powerdown_q, .lock_allow, .pll_locked, .host_active, .pd_pin,
    .serial_data, .serial_clock_or_powerdown
  );

  always #5 aclk = ~aclk;
  always @(posedge aclk) if (watch3 && bank_run_q[2] !== 1'b1) drop3 <= 1'b1;

  task give_verdict;
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task automatic check_val(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : check_val

  function automatic logic [31:0] lv();
    return {20'h0, bank_run_q, bank_true_output_q, bank_complement_output_q};
  endfunction : lv

  task automatic axi_write(input logic [7:0] a, input logic [31:0] v,
                           output logic [1:0] resp);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, v, 4'hF};
    {awvalid, wvalid, bready} <= 3'h7;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] v,
                          output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_read

  task automatic set_sel(input logic [1:0] c);
    @(posedge aclk);
    {freq_select_bank_one, freq_select_bank_two} <= {c, c};
    {freq_select_bank_three, freq_select_bank_four_first} <= {c, c};
    freq_select_bank_four_second <= c;
  endtask : set_sel

  task automatic saw_drop(input int b, input string nm);
    logic s;
    s = 1'b0;
    repeat (20) begin
      @(posedge aclk);
      if (bank_run_q[b] === 1'b0) s = 1'b1;
    end
    check_val(nm, 32'h1, s);
  endtask : saw_drop

  initial begin
    #100us;
    miscompares++;
    give_verdict();
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      axi_read(8'(4 * i), d, r);
      check_val("reset value", rst_exp[i], d);
    end
    repeat (30) @(posedge aclk);
    check_val("levels before lock", 32'h00F, lv());
    lock_allow <= 1'b1;
    for (int l = 0; l < 3; l++) begin
      set_sel(pin_lvl[l]);
      repeat (50) @(posedge aclk);
      check_val("strap freq", {16'h0, 4'(4 * l), {3{4'(l)}}}, bank_freq_q);
      dx = {d4[4 * l], d3[l], d2[l], d1[l]};
      check_val("strap diff", dx, bank_diff_q);
      check_val("strap frac", f4[4 * l], bank4_frac_q);
      check_val("strap levels", {4'hF, 4'h0, dx}, lv());
    end
    axi_read(8'h14, d, r);
    check_val("status strap", 32'h1F2, d);
    freq_select_bank_one <= 2'h0;
    saw_drop(0, "strap select hold");
    repeat (30) @(posedge aclk);
    check_val("new strap freq", 32'h8220, bank_freq_q);
    mixed_mode_ctrl <= 1'b1;
    repeat (30) @(posedge aclk);
    check_val("mixed pin in strap", 32'h8220, bank_freq_q);
    check_val("levels mixed pin", 32'hF0E, lv());
    {mixed_mode_ctrl, pd_pin} <= 2'h1;
    repeat (30) @(posedge aclk);
    check_val("pin powerdown", 32'h1, pll_powerdown_q);
    check_val("levels powerdown", 32'h000, lv());
    pd_pin <= 1'b0;
    repeat (10) @(posedge aclk);
    check_val("levels restart", 32'h00F, lv());
    repeat (50) @(posedge aclk);
    check_val("levels relock", 32'hF0E, lv());
    host_active <= 1'b1;
    repeat (100) @(posedge aclk);
    host_active <= 1'b0;
    repeat (40) @(posedge aclk);
    axi_read(8'h14, d, r);
    check_val("serial mode", 32'h1, d[0]);
    check_val("pin ignored", 32'h0, pll_powerdown_q);
    check_val("serial defaults", 32'h0, bank_freq_q);
    watch3 <= 1'b1;
    axi_write(8'h04, 32'h13, r);
    axi_write(8'h08, 32'h05, r);
    axi_write(8'h10, 32'h6A, r);
    saw_drop(3, "serial retune");
    repeat (20) @(posedge aclk);
    check_val("serial freq", 32'hA053, bank_freq_q);
    check_val("serial diff", 32'h1, bank_diff_q);
    check_val("serial frac", 32'h1, bank4_frac_q);
    check_val("serial levels", 32'hC01, lv());
    watch3 <= 1'b0;
    check_val("other bank kept", 32'h0, drop3);
    axi_read(8'h04, d, r);
    check_val("cfg readback", 32'h13, d);
    axi_write(8'h10, 32'h2B, r);
    repeat (20) @(posedge aclk);
    check_val("second file", 32'h0B, {bank4_frac_q, bank_freq_q[15:12]});
    axi_write(8'h00, 32'h01, r);
    repeat (3) @(posedge aclk);
    check_val("bypass", 32'h1, pll_bypass_q);
    axi_write(8'h00, 32'h10, r);
    mixed_mode_ctrl <= 1'b1;
    repeat (30) @(posedge aclk);
    check_val("mixed strap bank", 32'h0, bank_freq_q[3:0]);
    check_val("mixed levels", 32'hC00, lv());
    mixed_mode_ctrl <= 1'b0;
    repeat (30) @(posedge aclk);
    check_val("mixed serial bank", 32'h3, bank_freq_q[3:0]);
    axi_write(8'h00, 32'h02, r);
    repeat (3) @(posedge aclk);
    check_val("serial powerdown", 32'h1, pll_powerdown_q);
    axi_write(8'h00, 32'h00, r);
    repeat (60) @(posedge aclk);
    check_val("serial relock", 32'hC01, lv());
    axi_read(8'h40, d, r);
    check_val("unmapped read", 32'h2, r);
    axi_write(8'h40, 32'hFF, r);
    check_val("unmapped write", 32'h2, r);
    axi_write(8'h14, 32'h0, r);
    check_val("status write", 32'h0, r);
    axi_read(8'h14, d, r);
    check_val("serial mode kept", 32'h1, d[0]);
    give_verdict();
  end
endmodule : test_multirate_clock_output_control
`default_nettype wire
